/* rtl/ircc_map.vh */
/*
  Register map, field positions, codes and reset values of the
  index, ring count and correction block.
  Assumes byte addressing on a 32-bit AXI4-Lite register bus.
*/
`ifndef IRCC_MAP_VH
`define IRCC_MAP_VH

`define IRCC_A_TERM  8'h00
`define IRCC_A_CIN   8'h04
`define IRCC_A_CMP   8'h08
`define IRCC_A_CORR  8'h0C
`define IRCC_A_LIM4  8'h10
`define IRCC_A_LIM1  8'h14
`define IRCC_A_LIM2  8'h18
`define IRCC_A_CNT1  8'h1C
`define IRCC_A_CNT2  8'h20
`define IRCC_A_CNT4  8'h24
`define IRCC_A_MOVE  8'h28
`define IRCC_A_SPD   8'h2C
`define IRCC_A_CSPD  8'h30
`define IRCC_A_START 8'h34
`define IRCC_A_STAT  8'h38

`define IRCC_R32     32'h0000_0000
`define IRCC_ONE32   32'h0000_0001
`define IRCC_R16     16'h0000
`define IRCC_RST_SPD 16'h0064

`define IRCC_TERM_FN  13:12
`define IRCC_CIN_SEL  13:12
`define IRCC_CIN_CU   27:24
`define IRCC_C1_SEL   1:0
`define IRCC_C1_METH  4:2
`define IRCC_C1_RING  7
`define IRCC_C2_SEL   9:8
`define IRCC_C2_METH  12:10
`define IRCC_C2_RING  15
`define IRCC_IDXM     23
`define IRCC_C4_SEL   25:24
`define IRCC_C4_METH  29:26
`define IRCC_CR_AMT   11:0
`define IRCC_CR_METH  13:12

`define IRCC_SEL_CMD  2'h0
`define IRCC_SEL_ENC  2'h1
`define IRCC_SEL_MPG  2'h2
`define IRCC_SEL_CLK  2'h3
`define IRCC_C1_SELV  2'h0
`define IRCC_C2_SELV  2'h1
`define IRCC_C4_SELV  2'h3
`define IRCC_METH_OFF 3'h0
`define IRCC_IX_ANY   4'h8
`define IRCC_IX_UP    4'h9
`define IRCC_IX_DN    4'hA
`define IRCC_FN_NEG   2'h2
`define IRCC_FN_POS   2'h3
`define IRCC_CR_BL    2'h1
`define IRCC_CR_SLIP  2'h2
`define IRCC_IDX_LEN  2'h2

`define IRCC_RESP_OK  2'h0
`define IRCC_RESP_DEC 2'h3

`endif

/* rtl/ircc_core.v */
/*
  Index output, ring counters and backlash/slip correction of one
  axis, with an AXI4-Lite register slave and a simple pulse sequencer.
  Assumes i_clk is the 20 MHz reference clock and that the pulse
  inputs come from pins, asynchronous to it.
*/
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
// Behaviour
// RULE_01: Index mode counts zero up to limit.
// RULE_02: Down from zero loads limit; up wraps.
// RULE_03: Host programs limit from one upward.
// RULE_04: Index needs counter code 11, index method.
// RULE_05: Method selects any, up-only, down-only index.
// RULE_06: Level mode: index while counter equals limit.
// RULE_07: Pulse mode: two cycles on counted zero.
// RULE_08: Writing zero never yields index pulse.
// RULE_09: Mode bit ignored without index method.
// RULE_10: Terminal function 10 inverted, 11 true.
// RULE_11: Input select: command, encoder, pulser, clock/2.
// RULE_12: Host uses limit two for restricted level.
// RULE_13: Command counter ring mode enable conditions.
// RULE_14: Command counter wraps at comparator one limit.
// RULE_15: Mechanical counter ring mode, comparator two limit.
// RULE_16: Moves beyond ring range still complete.
// RULE_17: Host keeps ring values in range.
// RULE_18: Correction pulses at correction speed precede move.
// RULE_19: Backlash on reversal, slip every command.
// RULE_20: Correction amount twelve bits, zero to 4095.
// RULE_21: Method: off, backlash, slip.
// RULE_22: Per-counter enables for counting correction pulses.
// RULE_23: Wrap and index evaluated on count edge.
`include "ircc_map.vh"
`timescale 1ns/100ps
`default_nettype none

module ircc_core (
  input  wire        i_clk,
  input  wire        i_rst,
  input  wire        i_ce,
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  input  wire        i_enc_up,
  input  wire        i_enc_dn,
  input  wire        i_mpg_up,
  input  wire        i_mpg_dn,
  output reg         o_pulse,
  output reg         o_dir,
  output reg         o_index_terminal,
  output reg         o_index_terminal_oe
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_CORR = 2'h1;
  localparam [1:0] ST_MOVE = 2'h2;

  reg [31:0] term_q, cin_q, cmp_q, corr_q;
  reg [31:0] lim4_q, lim1_q, lim2_q;
  reg [31:0] cnt1_q, cnt2_q, cnt4_q, move_q, mcnt_q;
  reg [15:0] spd_q, cspd_q, tmr_q;
  reg [11:0] ccnt_q;
  reg [1:0]  st_q, str_q;
  reg        dir_q, last_dir_q, half_q, c4_dir_q;
  reg [3:0]  s1_q, s2_q, s3_q;
  reg [7:0]  awa_q;
  reg [31:0] wd_q;
  reg [3:0]  ws_q;
  reg        awf_q, wf_q;

  function [31:0] step;
    input [31:0] v;
    input        up;
    input        ring;
    input [31:0] lim;
    begin
      if (ring && up && v == lim) begin
        step = `IRCC_R32;
      end else if (ring && !up && v == `IRCC_R32) begin
        step = lim;
      end else if (up) begin
        step = v + `IRCC_ONE32;
      end else begin
        step = v - `IRCC_ONE32;
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] d;
    input [3:0]  s;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (s[k]) begin
          merge[k*8 +: 8] = d[k*8 +: 8];
        end
      end
    end
  endfunction

  function [15:0] pm1;
    input [15:0] p;
    begin
      pm1 = (p == `IRCC_R16) ? `IRCC_R16 : p - 16'h0001;
    end
  endfunction

  // Pin events: two flops resync, the third only feeds edge detection.
  wire [3:0] rise = s2_q & ~s3_q;

  wire wr_go = awf_q & wf_q & ~o_bvalid;
  wire wr1   = wr_go && awa_q == `IRCC_A_CNT1;
  wire wr2   = wr_go && awa_q == `IRCC_A_CNT2;
  wire wr4   = wr_go && awa_q == `IRCC_A_CNT4;
  wire wr_st = wr_go && awa_q == `IRCC_A_START && ws_q[0] && wd_q[0];

  wire        pulse_ev = (st_q != ST_IDLE) && (tmr_q == `IRCC_R16);
  wire        is_corr  = (st_q == ST_CORR);
  wire [3:0]  cu       = cin_q[`IRCC_CIN_CU];
  wire        cmd_up   = ~dir_q;
  wire        ev1 = pulse_ev & (~is_corr | cu[0]); // [RULE_22]
  wire        ev2 = pulse_ev & (~is_corr | cu[1]); // [RULE_22]
  wire        ev4c = pulse_ev & (~is_corr | cu[3]); // [RULE_22]

  wire ring1 = cmp_q[`IRCC_C1_RING]
    && cmp_q[`IRCC_C1_METH] == `IRCC_METH_OFF
    && cmp_q[`IRCC_C1_SEL] == `IRCC_C1_SELV; // [RULE_13]
  wire ring2 = cmp_q[`IRCC_C2_RING]
    && cmp_q[`IRCC_C2_METH] == `IRCC_METH_OFF
    && cmp_q[`IRCC_C2_SEL] == `IRCC_C2_SELV; // [RULE_15]

  wire [3:0] m4 = cmp_q[`IRCC_C4_METH];
  wire idx_on = cmp_q[`IRCC_C4_SEL] == `IRCC_C4_SELV
    && (m4 == `IRCC_IX_ANY || m4 == `IRCC_IX_UP
    || m4 == `IRCC_IX_DN); // [RULE_04]

  function dir_ok;
    input [3:0] m;
    input       up;
    begin
      dir_ok = (m == `IRCC_IX_ANY) || (m == `IRCC_IX_UP && up)
        || (m == `IRCC_IX_DN && !up); // [RULE_05]
    end
  endfunction

  reg c4_ev, c4_up;
  always @* begin
    c4_ev = 1'b0;
    c4_up = 1'b1;
    case (cin_q[`IRCC_CIN_SEL]) // [RULE_11]
      `IRCC_SEL_CMD: begin
        c4_ev = ev4c;
        c4_up = cmd_up;
      end
      `IRCC_SEL_ENC: begin
        c4_ev = rise[0] ^ rise[1];
        c4_up = rise[0];
      end
      `IRCC_SEL_MPG: begin
        c4_ev = rise[2] ^ rise[3];
        c4_up = rise[2];
      end
      default: begin
        c4_ev = half_q;
        c4_up = 1'b1;
      end
    endcase
  end

  // Counts and wrap are resolved on the same edge as the count input.
  wire [31:0] n1 = step(cnt1_q, cmd_up, ring1, lim1_q); // [RULE_14] [RULE_16] [RULE_23]
  wire [31:0] n2 = step(cnt2_q, cmd_up, ring2, lim2_q); // [RULE_15] [RULE_23]
  wire [31:0] n4 = step(cnt4_q, c4_up, idx_on, lim4_q); // [RULE_01] [RULE_02] [RULE_23]

  wire        c4_cnt = c4_ev & ~wr4;
  wire [31:0] cnt1_d = wr1 ? merge(cnt1_q, wd_q, ws_q) : (ev1 ? n1 : cnt1_q);
  wire [31:0] cnt2_d = wr2 ? merge(cnt2_q, wd_q, ws_q) : (ev2 ? n2 : cnt2_q);
  wire [31:0] cnt4_d = wr4 ? merge(cnt4_q, wd_q, ws_q) : (c4_cnt ? n4 : cnt4_q);
  wire        c4_dir_d = c4_cnt ? c4_up : c4_dir_q;

  // A write or reset to zero is no count, so it cannot start a pulse.
  reg [1:0] str_d;
  always @* begin
    str_d = 2'h0;
    if (idx_on && c4_cnt && n4 == `IRCC_R32 && dir_ok(m4, c4_up)) begin
      str_d = `IRCC_IDX_LEN; // [RULE_07] [RULE_08]
    end else if (idx_on && str_q != 2'h0) begin
      str_d = str_q - 2'h1;
    end
  end

  wire lvl = (cnt4_d == lim4_q) && dir_ok(m4, c4_dir_d); // [RULE_06]
  wire idx_raw = idx_on
    && (cmp_q[`IRCC_IDXM] ? (str_d != 2'h0) : lvl); // [RULE_09]
  wire [1:0] fn = term_q[`IRCC_TERM_FN];
  wire [31:0] spd_m  = merge({16'h0000, spd_q}, wd_q, ws_q);
  wire [31:0] cspd_m = merge({16'h0000, cspd_q}, wd_q, ws_q);

  wire [31:0] mabs = move_q[31] ? (`IRCC_R32 - move_q) : move_q;
  wire        ndir = move_q[31];
  wire [11:0] camt = corr_q[`IRCC_CR_AMT]; // [RULE_20]
  wire [1:0]  cmeth = corr_q[`IRCC_CR_METH];
  wire need_corr = camt != 12'h000
    && ((cmeth == `IRCC_CR_BL && ndir != last_dir_q)
    || cmeth == `IRCC_CR_SLIP); // [RULE_19] [RULE_21]

  reg [31:0] rd_d;
  reg        rd_ok;
  always @* begin
    rd_d = `IRCC_R32;
    rd_ok = 1'b1;
    case (i_araddr)
      `IRCC_A_TERM, `IRCC_A_CIN, `IRCC_A_CMP, `IRCC_A_CORR,
      `IRCC_A_START: rd_d = `IRCC_R32;
      `IRCC_A_LIM4: rd_d = lim4_q;
      `IRCC_A_LIM1: rd_d = lim1_q;
      `IRCC_A_LIM2: rd_d = lim2_q;
      `IRCC_A_CNT1: rd_d = cnt1_q;
      `IRCC_A_CNT2: rd_d = cnt2_q;
      `IRCC_A_CNT4: rd_d = cnt4_q;
      `IRCC_A_MOVE: rd_d = move_q;
      `IRCC_A_SPD:  rd_d = {16'h0000, spd_q};
      `IRCC_A_CSPD: rd_d = {16'h0000, cspd_q};
      `IRCC_A_STAT: rd_d = {27'h0, o_index_terminal, last_dir_q,
                            dir_q, is_corr, st_q != ST_IDLE};
      default: rd_ok = 1'b0;
    endcase
  end

  reg wr_ok;
  always @* begin
    case (awa_q)
      `IRCC_A_TERM, `IRCC_A_CIN, `IRCC_A_CMP, `IRCC_A_CORR,
      `IRCC_A_LIM4, `IRCC_A_LIM1, `IRCC_A_LIM2, `IRCC_A_CNT1,
      `IRCC_A_CNT2, `IRCC_A_CNT4, `IRCC_A_MOVE, `IRCC_A_SPD,
      `IRCC_A_CSPD, `IRCC_A_START, `IRCC_A_STAT: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_rst) begin
      term_q <= `IRCC_R32;
      cin_q <= `IRCC_R32;
      cmp_q <= `IRCC_R32;
      corr_q <= `IRCC_R32;
      lim4_q <= `IRCC_R32;
      lim1_q <= `IRCC_R32;
      lim2_q <= `IRCC_R32;
      cnt1_q <= `IRCC_R32;
      cnt2_q <= `IRCC_R32;
      cnt4_q <= `IRCC_R32;
      move_q <= `IRCC_R32;
      mcnt_q <= `IRCC_R32;
      spd_q <= `IRCC_RST_SPD;
      cspd_q <= `IRCC_RST_SPD;
      tmr_q <= `IRCC_R16;
      ccnt_q <= 12'h000;
      st_q <= ST_IDLE;
      str_q <= 2'h0;
      dir_q <= 1'b0;
      last_dir_q <= 1'b0;
      half_q <= 1'b0;
      c4_dir_q <= 1'b1;
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      awa_q <= 8'h00;
      wd_q <= `IRCC_R32;
      ws_q <= 4'h0;
      awf_q <= 1'b0;
      wf_q <= 1'b0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= `IRCC_RESP_OK;
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= `IRCC_R32;
      o_rresp <= `IRCC_RESP_OK;
      o_pulse <= 1'b0;
      o_dir <= 1'b0;
      o_index_terminal <= 1'b0;
      o_index_terminal_oe <= 1'b0;
    end else if (i_ce) begin
      s1_q <= {i_mpg_dn, i_mpg_up, i_enc_dn, i_enc_up};
      s2_q <= s1_q;
      s3_q <= s2_q;
      half_q <= ~half_q;
      cnt1_q <= cnt1_d;
      cnt2_q <= cnt2_d;
      cnt4_q <= cnt4_d;
      c4_dir_q <= c4_dir_d;
      str_q <= str_d;
      o_pulse <= pulse_ev;
      o_dir <= (wr_st && st_q == ST_IDLE) ? ndir : dir_q;
      o_index_terminal <= (fn == `IRCC_FN_NEG) ? ~idx_raw
                        : (fn == `IRCC_FN_POS) ? idx_raw : 1'b0; // [RULE_10]
      o_index_terminal_oe <= (fn == `IRCC_FN_NEG) || (fn == `IRCC_FN_POS);

      if (o_awready && i_awvalid) begin
        awa_q <= i_awaddr;
        awf_q <= 1'b1;
        o_awready <= 1'b0;
      end
      if (o_wready && i_wvalid) begin
        wd_q <= i_wdata;
        ws_q <= i_wstrb;
        wf_q <= 1'b1;
        o_wready <= 1'b0;
      end
      if (wr_go) begin
        awf_q <= 1'b0;
        wf_q <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= wr_ok ? `IRCC_RESP_OK : `IRCC_RESP_DEC;
        case (awa_q)
          `IRCC_A_TERM: term_q <= merge(term_q, wd_q, ws_q);
          `IRCC_A_CIN:  cin_q <= merge(cin_q, wd_q, ws_q);
          `IRCC_A_CMP:  cmp_q <= merge(cmp_q, wd_q, ws_q);
          `IRCC_A_CORR: corr_q <= merge(corr_q, wd_q, ws_q);
          `IRCC_A_LIM4: lim4_q <= merge(lim4_q, wd_q, ws_q);
          `IRCC_A_LIM1: lim1_q <= merge(lim1_q, wd_q, ws_q);
          `IRCC_A_LIM2: lim2_q <= merge(lim2_q, wd_q, ws_q);
          `IRCC_A_MOVE: move_q <= merge(move_q, wd_q, ws_q);
          `IRCC_A_SPD:  spd_q <= spd_m[15:0];
          `IRCC_A_CSPD: cspd_q <= cspd_m[15:0];
          default: ;
        endcase
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
      if (o_arready && i_arvalid) begin
        o_arready <= 1'b0;
        o_rvalid <= 1'b1;
        o_rdata <= rd_d;
        o_rresp <= rd_ok ? `IRCC_RESP_OK : `IRCC_RESP_DEC;
      end
      if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
        o_arready <= 1'b1;
      end

      // Correction pulses go out first, at their own rate, then the move.
      case (st_q)
        ST_IDLE: begin
          if (wr_st) begin
            dir_q <= ndir;
            last_dir_q <= ndir;
            mcnt_q <= mabs;
            tmr_q <= `IRCC_R16;
            ccnt_q <= camt;
            if (need_corr) begin
              st_q <= ST_CORR; // [RULE_18] [RULE_19]
            end else if (mabs != `IRCC_R32) begin
              st_q <= ST_MOVE;
            end
          end
        end
        ST_CORR: begin
          if (pulse_ev) begin
            ccnt_q <= ccnt_q - 12'h001;
            tmr_q <= pm1(cspd_q); // [RULE_18]
            if (ccnt_q == 12'h001) begin
              tmr_q <= pm1(spd_q);
              st_q <= (mcnt_q != `IRCC_R32) ? ST_MOVE : ST_IDLE;
            end
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        ST_MOVE: begin
          if (pulse_ev) begin
            mcnt_q <= mcnt_q - `IRCC_ONE32; // [RULE_16]
            tmr_q <= pm1(spd_q);
            if (mcnt_q == `IRCC_ONE32) begin
              st_q <= ST_IDLE;
            end
          end else begin
            tmr_q <= tmr_q - 16'h0001;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

/* testbench/ircc_monitor.sv */
/*
  Concurrent checks on the register bus and the index terminal of ircc_core.
  Assumes the bench holds i_ce high for the whole run.
*/
`timescale 1ns/100ps
`default_nettype none
module ircc_monitor (
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_awvalid,
  input wire logic        o_awready,
  input wire logic        i_wvalid,
  input wire logic        o_wready,
  input wire logic [1:0]  o_bresp,
  input wire logic        o_bvalid,
  input wire logic        i_bready,
  input wire logic        i_arvalid,
  input wire logic        o_arready,
  input wire logic [31:0] o_rdata,
  input wire logic        o_rvalid,
  input wire logic        i_rready,
  input wire logic        o_pulse,
  input wire logic        o_dir,
  input wire logic        o_index_terminal,
  input wire logic        o_index_terminal_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  b_hold_a: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped early");
  r_hold_a: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
    else $error("read data dropped early");
  b_latency_a: assert property (i_awvalid && o_awready && i_wvalid && o_wready |=> ##1 o_bvalid)
    else $error("write response late");
  r_latency_a: assert property (i_arvalid && o_arready |=> o_rvalid)
    else $error("read data late");
  aw_block_a: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write accepted while response pending");
  ar_block_a: assert property (o_rvalid |-> !o_arready)
    else $error("read accepted while data pending");
  idx_idle_a: assert property (!o_index_terminal_oe |-> !o_index_terminal)
    else $error("index terminal driven while not routed");
  dir_hold_a: assert property (o_pulse |-> $stable(o_dir))
    else $error("direction moved under a pulse");
endmodule
bind ircc_core ircc_monitor u_mon (.i_clk, .i_rst, .i_awvalid, .o_awready, .i_wvalid, .o_wready,
  .o_bresp, .o_bvalid, .i_bready, .i_arvalid, .o_arready, .o_rdata, .o_rvalid, .i_rready,
  .o_pulse, .o_dir, .o_index_terminal, .o_index_terminal_oe);
`default_nettype wire

/* testbench/ircc_drive_model.sv */
/*
  Motor driver model: counts command pulses and position, and echoes each
  pulse as a two-cycle encoder pulse LAG+1 cycles later. Assumes LAG below 7.
*/
`timescale 1ns/100ps
`default_nettype none
module ircc_drive_model #(
  parameter int LAG = 2
) (
  input  wire logic i_clk,
  input  wire logic i_pulse,
  input  wire logic i_dir,
  output logic      o_enc_up,
  output logic      o_enc_dn,
  output int        o_pos,
  output int        o_count
);
  logic [7:0] up_q = 8'h00;
  logic [7:0] dn_q = 8'h00;
  int         pos_q = 0;
  int         cnt_q = 0;
  always @(posedge i_clk) begin
    up_q <= {up_q[6:0], i_pulse & ~i_dir};
    dn_q <= {dn_q[6:0], i_pulse & i_dir};
    if (i_pulse === 1'b1) begin
      cnt_q <= cnt_q + 1;
      pos_q <= (i_dir === 1'b1) ? pos_q - 1 : pos_q + 1;
    end
  end
  assign o_enc_up = up_q[LAG] | up_q[LAG+1];
  assign o_enc_dn = dn_q[LAG] | dn_q[LAG+1];
  assign o_pos = pos_q;
  assign o_count = cnt_q;
endmodule
`default_nettype wire

/* testbench/test_index_ring_count_correction.sv */
/*
  Self-checking bench for ircc_core: ring counting, index output and
  correction pulses driven over AXI4-Lite. Assumes a 20 MHz clock.
*/
`include "ircc_map.vh"
`timescale 1ns/100ps
`default_nettype none
module test_index_ring_count_correction;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, arv = 1'b0, mu = 1'b0, md = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, v;
  logic [1:0]  rsp, bresp, rresp;
  logic [31:0] rdata;
  logic        awr, wrd, bv, arr, rv, pul, dir, idx, oe, eu, ed;
  int          pos, cnt, c0, h0, hi_cnt = 0, error_cnt = 0, tests_run = 0;

  ircc_core dut (.i_clk(clk), .i_rst(rst), .i_ce(1'b1), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr),
    .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrd), .o_bresp(bresp), .o_bvalid(bv),
    .i_bready(1'b1), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rdata),
    .o_rresp(rresp), .o_rvalid(rv), .i_rready(1'b1), .i_enc_up(eu), .i_enc_dn(ed), .i_mpg_up(mu),
    .i_mpg_dn(md), .o_pulse(pul), .o_dir(dir), .o_index_terminal(idx), .o_index_terminal_oe(oe));
  ircc_drive_model #(.LAG(3)) u_drv (.i_clk(clk), .i_pulse(pul), .i_dir(dir), .o_enc_up(eu),
    .o_enc_dn(ed), .o_pos(pos), .o_count(cnt));

  always #25 clk = ~clk;
  always @(posedge clk) if (idx === 1'b1) hi_cnt <= hi_cnt + 1;

  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; n = 0;
    do begin
      @(posedge clk); n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (wrd === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    if (bv !== 1'b1) begin
      error_cnt++;
      $display("unexpected write response: expected 1 seen 0");
    end
    rsp = bresp;
  endtask
  task rd(input logic [7:0] a);
    int n;
    ara <= a; arv <= 1'b1; n = 0;
    do begin
      @(posedge clk); n++;
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    if (rv !== 1'b1) begin
      error_cnt++;
      $display("unexpected read response: expected 1 seen 0");
    end
    v = rdata; rsp = rresp;
  endtask
  task rdck(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(v, exp, "register");
  endtask
  // One manual pulser pulse, then time for the pin synchroniser to count it.
  task pin(input logic up);
    if (up) mu <= 1'b1; else md <= 1'b1;
    repeat (2) @(posedge clk);
    mu <= 1'b0; md <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task mv(input logic [31:0] amt);
    int n;
    wr(`IRCC_A_MOVE, amt);
    wr(`IRCC_A_START, 32'h1);
    v = 32'h1;
    for (n = 0; n < 12000 && v[0] !== 1'b0; n++) rd(`IRCC_A_STAT);
    chk({31'h0, v[0]}, 32'h0, "busy");
  endtask

  initial begin
    #4000000;
    error_cnt++;
    stop_test;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdck(`IRCC_A_CNT1, 32'h0);
    rdck(`IRCC_A_STAT, 32'h0);
    chk({31'h0, oe}, 32'h0, "terminal enable");
    wr(8'h3C, 32'h1);
    chk({30'h0, rsp}, 32'h3, "write response");
    rd(8'h3C);
    chk({30'h0, rsp}, 32'h3, "read response");
    wr(`IRCC_A_CMP, 32'h0000_8180);
    rdck(`IRCC_A_CMP, 32'h0);
    wr(`IRCC_A_LIM1, 32'h4);
    wr(`IRCC_A_LIM2, 32'h5);
    wr(`IRCC_A_SPD, 32'h4);
    wr(`IRCC_A_CSPD, 32'h4);
    mv(32'h7);
    rdck(`IRCC_A_CNT1, 32'h2);
    rdck(`IRCC_A_CNT2, 32'h1);
    chk(pos, 32'h7, "drive position");
    mv(32'hFFFF_FFFD);
    rdck(`IRCC_A_CNT1, 32'h4);
    rdck(`IRCC_A_CNT2, 32'h4);
    wr(`IRCC_A_TERM, 32'h0000_3000);
    wr(`IRCC_A_CIN, 32'h0000_2000);
    wr(`IRCC_A_CMP, 32'h2300_0000);
    wr(`IRCC_A_LIM4, 32'h3);
    wr(`IRCC_A_CNT4, 32'h0);
    repeat (3) pin(1'b1);
    rdck(`IRCC_A_CNT4, 32'h3);
    chk({31'h0, idx}, 32'h1, "index");
    chk({31'h0, oe}, 32'h1, "terminal enable");
    pin(1'b1);
    rdck(`IRCC_A_CNT4, 32'h0);
    chk({31'h0, idx}, 32'h0, "index");
    pin(1'b0);
    rdck(`IRCC_A_CNT4, 32'h3);
    chk({31'h0, idx}, 32'h1, "index");
    wr(`IRCC_A_CMP, 32'h2700_0000);
    pin(1'b0);
    pin(1'b1);
    chk({31'h0, idx}, 32'h1, "index");
    pin(1'b1);
    pin(1'b0);
    chk({31'h0, idx}, 32'h0, "index");
    wr(`IRCC_A_TERM, 32'h0000_2000);
    wr(`IRCC_A_CMP, 32'h2B00_0000);
    @(posedge clk);
    chk({31'h0, idx}, 32'h0, "index");
    pin(1'b0);
    pin(1'b1);
    chk({31'h0, idx}, 32'h1, "index");
    wr(`IRCC_A_TERM, 32'h0000_3000);
    wr(`IRCC_A_CMP, 32'h2380_0000);
    h0 = hi_cnt;
    wr(`IRCC_A_CNT4, 32'h0);
    repeat (10) @(posedge clk);
    chk(hi_cnt - h0, 32'h0, "index cycles");
    repeat (3) pin(1'b1);
    h0 = hi_cnt;
    pin(1'b1);
    chk(hi_cnt - h0, 32'h2, "index cycles");
    wr(`IRCC_A_CMP, 32'h0380_0000);
    h0 = hi_cnt;
    pin(1'b0);
    pin(1'b1);
    chk(hi_cnt - h0, 32'h0, "index cycles");
    wr(`IRCC_A_CMP, 32'h0);
    wr(`IRCC_A_CNT1, 32'h0);
    wr(`IRCC_A_CNT2, 32'h0);
    wr(`IRCC_A_CIN, 32'h0100_0000);
    wr(`IRCC_A_CORR, 32'h0000_1002);
    c0 = cnt;
    mv(32'h3);
    chk(cnt - c0, 32'h5, "pulse count");
    rdck(`IRCC_A_CNT1, 32'h5);
    rdck(`IRCC_A_CNT2, 32'h3);
    c0 = cnt;
    mv(32'h3);
    chk(cnt - c0, 32'h3, "pulse count");
    wr(`IRCC_A_CORR, 32'h0000_2002);
    c0 = cnt;
    mv(32'h1);
    chk(cnt - c0, 32'h3, "pulse count");
    wr(`IRCC_A_CORR, 32'h0000_0002);
    c0 = cnt;
    mv(32'h1);
    chk(cnt - c0, 32'h1, "pulse count");
    wr(`IRCC_A_CORR, 32'h0000_1FFF);
    c0 = cnt;
    mv(32'hFFFF_FFFF);
    chk(cnt - c0, 32'd4096, "pulse count");
    stop_test;
  end
endmodule
`default_nettype wire
